// [pkg/flash_rd_cfg.svh]
// constants for the burst read sequencer: command word fields, latency coding, timing
`ifndef FLASH_RD_CFG_SVH
`define FLASH_RD_CFG_SVH

// command/address bit positions
`define CA_RW_BIT       47
`define CA_BURST_BIT    45
`define CA_HP_LSB       16
`define CA_WORD_W       3
// command/address byte slices (rising edge takes the upper byte of each word)
`define CA_B5_LSB       40
`define CA_B4_LSB       32
`define CA_B3_LSB       24
`define CA_B2_LSB       16
`define CA_B1_LSB       8
`define CA_B0_LSB       0
// clock count values at which the command/address bytes are captured
`define CYC_CA0         6'h00
`define CYC_CA1         6'h01
`define CYC_CA2         6'h02
`define CYC_CA_DONE     6'h03
`define CYC_MAX         6'h3f
// clock count of the last command clock; the first data clock comes latency clocks after it
`define DATA_LEAD       6'h02
// latency coding: code 0 is five clocks, one more per step
`define LAT_BASE        5'h05
`define LAT_MAX_CODE    4'hb
`define NV_LAT_DEFAULT  4'hb
// page geometry in words and wrap masks in words
`define PAGE_MASK       4'hf
`define WRAP16_MASK     5'h07
`define WRAP32_MASK     5'h0f
`define WRAP64_MASK     5'h1f

`endif

// [pkg/flash_rd_pkg.sv]
// types shared by the burst read sequencer
package flash_rd_pkg;

  // link-side sequencer state, one-hot
  typedef enum logic [3:0] {
    ST_CA   = 4'h1,  // collecting command/address bytes
    ST_LAT  = 4'h2,  // latency clocks
    ST_DATA = 4'h4,  // streaming words
    ST_SKIP = 4'h8   // not a read: stay off the bus
  } link_state_t;

  // wrapped burst length selection
  typedef enum logic [1:0] {
    WRAP16B = 2'h0,
    WRAP32B = 2'h1,
    WRAP64B = 2'h2
  } wrap_sel_t;

endpackage : flash_rd_pkg

// [core/flash_burst_read.sv]
// burst read sequencer of a double-data-rate serial NOR flash
//
// Notes on behaviour
// [RULE1] three command words captured over six edges
// [RULE2] bit 47 high means read, else write
// [RULE3] upper byte on rise, lower on fall
// [RULE4] first word gives read and burst type
// [RULE5] array access starts once half-page captured
// [RULE6] third word picks starting word in half-page
// [RULE7] host clocks through latency before data
// [RULE8] strobe and data start together after latency
// [RULE9] new byte every strobe edge, edge aligned
// [RULE10] data flows while host keeps clocking
// [RULE11] wrap inside burst length; linear crosses pages
// [RULE12] hybrid: one wrap then linear
// [RULE13] wraps work for every address space
// [RULE14] host ends read raising select, clock low
// [RULE15] linear burst rolls over to zero
// [RULE16] 16/32-byte wraps never insert page waits
// [RULE17] 64-byte wrap may wait crossing pages
// [RULE18] host starts clock low, deselects between transactions
// [RULE19] latency from volatile or non-volatile setting
// [RULE20] code 0 is 5 clocks, up to 16
// [RULE21] host picks code fit for clock rate
// [RULE22] non-volatile latency defaults to 16 clocks
// [RULE23] burst bit high selects linear addressing
// [RULE24] first crossing waits latency minus words sent
// [RULE25] bus and strobe released outside read data
`timescale 1ns/100ps
`include "flash_rd_cfg.svh"

module flash_burst_read #(
  parameter int ADDR_W = 25  // word address width of the array
) (
  // system clock domain
  input  wire logic                      CLOCK,
  input  wire logic                      SRST,
  // link pins
  input  wire logic                      CK,
  input  wire logic                      CK_COMP,
  input  wire logic                      CS_N,
  input  wire logic [7:0]                DQ_IN,
  output logic      [7:0]                DQ_OUT,
  output logic                           DQ_OE,
  output logic                           READ_DATA_STROBE_OUT,
  output logic                           READ_DATA_STROBE_OE,
  // array read port, link clock domain
  output logic      [ADDR_W-1:0]         ARRAY_ADDR,
  output logic                           ARRAY_START,
  input  wire logic [15:0]               ARRAY_DATA,
  // configuration, system clock domain
  input  wire logic [3:0]                VOL_LAT_CODE,
  input  wire logic                      USE_NV_LAT,
  input  wire logic                      NV_LAT_WE,
  input  wire logic [3:0]                NV_LAT_DATA,
  input  wire flash_rd_pkg::wrap_sel_t   WRAP_SEL,
  input  wire logic                      HYBRID_EN,
  // status, system clock domain
  output logic      [3:0]                NV_LAT_CODE,
  output logic                           READ_ACTIVE,
  output logic      [7:0]                READ_COUNT
);
  import flash_rd_pkg::*;

  localparam logic [ADDR_W-1:0] ONE = {{(ADDR_W-1){1'b0}}, 1'b1};

  // wrap mask in words for a burst length selection
  function automatic logic [ADDR_W-1:0] wrap_mask(input wrap_sel_t sel);
    logic [4:0] m;
    m = `WRAP16_MASK;
    if (sel == WRAP32B) begin
      m = `WRAP32_MASK;
    end else if (sel == WRAP64B) begin
      m = `WRAP64_MASK;
    end
    return {{(ADDR_W-5){1'b0}}, m};
  endfunction : wrap_mask

  // ---------------- system clock domain ----------------
  logic [3:0]  nv_lat_ff;      // non-volatile latency code
  logic [7:0]  cfg_ff;         // {hybrid, wrap sel, spare, latency code}
  logic [7:0]  nxt_cfg;        // next configuration word
  logic        act_s1_ff;      // read active synchroniser, first stage
  logic        act_s2_ff;      // read active synchroniser, second stage
  logic        tog_s1_ff;      // read access flag, first stage
  logic        tog_s2_ff;      // read access flag, second stage
  logic        tog_s3_ff;      // delayed copy for edge detect
  logic [7:0]  count_ff;       // reads accepted

  // non-volatile latency setting, factory default of sixteen clocks
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      nv_lat_ff <= `NV_LAT_DEFAULT; // RULE22
    end else if (NV_LAT_WE) begin
      nv_lat_ff <= NV_LAT_DATA;
    end
  end

  // choose the active latency code; reserved codes are clamped to the longest
  always_comb begin
    logic [3:0] code;
    code = USE_NV_LAT ? nv_lat_ff : VOL_LAT_CODE; // RULE19
    if (code > `LAT_MAX_CODE) begin
      code = `LAT_MAX_CODE; // RULE20
    end
    nxt_cfg = {HYBRID_EN, WRAP_SEL, 1'b0, code};
  end

  // registered configuration handed to the link side
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cfg_ff <= {3'h0, 1'b0, `NV_LAT_DEFAULT};
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // status crossings from the link side
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      act_s1_ff <= 1'b0;
      act_s2_ff <= 1'b0;
      tog_s1_ff <= 1'b0;
      tog_s2_ff <= 1'b0;
      tog_s3_ff <= 1'b0;
    end else begin
      act_s1_ff <= rd_oe_ff;
      act_s2_ff <= act_s1_ff;
      tog_s1_ff <= start_ff;
      tog_s2_ff <= tog_s1_ff;
      tog_s3_ff <= tog_s2_ff;
    end
  end

  // count accepted reads on each rise of the access flag; select high clears it between frames
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      count_ff <= 8'h00;
    end else if (tog_s2_ff && !tog_s3_ff) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  assign NV_LAT_CODE = nv_lat_ff;
  assign READ_ACTIVE = act_s2_ff;
  assign READ_COUNT  = count_ff;

  // ---------------- link clock domain ----------------
  // configuration is quasi-static: it must not change while select is low
  logic [7:0]        cfg_s1_ff;       // config synchroniser, first stage
  logic [7:0]        cfg_s2_ff;       // config synchroniser, second stage
  link_state_t       state_ff;        // sequencer state
  logic [5:0]        cyc_ff;          // clocks since select fell
  logic [7:0]        ca5_ff;          // bits 47:40
  logic [7:0]        ca3_ff;          // bits 31:24
  logic [7:0]        ca1_ff;          // bits 15:8
  logic [7:0]        ca4_ff;          // bits 39:32
  logic [7:0]        ca2_ff;          // bits 23:16
  logic [7:0]        ca0_ff;          // bits 7:0
  logic [ADDR_W-1:0] addr_ff;         // next word to send
  logic              start_ff;        // array access launched
  logic              linear_ff;       // linear addressing now
  logic              crossed_ff;      // first page crossing done
  logic [5:0]        words_ff;        // words sent so far
  logic [4:0]        wait_ff;         // page crossing wait clocks left
  logic [15:0]       word_ff;         // word on the bus
  logic              strobe_en_ff;    // strobe toggles this clock
  logic              rd_oe_ff;        // bus driven
  logic [7:0]        lo_ff;           // lower byte for the falling half
  logic [4:0]        lat_clk;         // latency in clocks
  logic [ADDR_W-1:0] wmask;           // active wrap mask
  logic [47:0]       ca;              // assembled command/address
  logic              hyb_switch;      // hybrid wrap block ends with this word
  logic              cross_now;       // this word is the first page end

  assign lat_clk = `LAT_BASE + {1'b0, cfg_s2_ff[3:0]}; // RULE20
  assign wmask   = wrap_mask(wrap_sel_t'(cfg_s2_ff[6:5]));
  assign ca      = {ca5_ff, ca4_ff, ca3_ff, ca2_ff, ca1_ff, ca0_ff};

  // configuration crossing into the link clock
  always_ff @(posedge CK) begin
    cfg_s1_ff <= cfg_ff;
    cfg_s2_ff <= cfg_s1_ff;
  end

  // rising-edge capture of command bytes; select high clears them at once
  always_ff @(posedge CK or posedge CS_N) begin
    if (CS_N) begin
      ca5_ff <= 8'h00;
      ca3_ff <= 8'h00;
      ca1_ff <= 8'h00;
    end else if (cyc_ff == `CYC_CA0) begin
      ca5_ff <= DQ_IN; // RULE1 RULE3
    end else if (cyc_ff == `CYC_CA1) begin
      ca3_ff <= DQ_IN; // RULE1
    end else if (cyc_ff == `CYC_CA2) begin
      ca1_ff <= DQ_IN; // RULE1
    end
  end

  // falling-edge capture: the counter has already stepped past the rising edge
  always_ff @(negedge CK or posedge CS_N) begin
    if (CS_N) begin
      ca4_ff <= 8'h00;
      ca2_ff <= 8'h00;
      ca0_ff <= 8'h00;
    end else if (cyc_ff == `CYC_CA1) begin
      ca4_ff <= DQ_IN; // RULE1 RULE3
    end else if (cyc_ff == `CYC_CA2) begin
      ca2_ff <= DQ_IN; // RULE1
    end else if (cyc_ff == `CYC_CA_DONE) begin
      ca0_ff <= DQ_IN; // RULE1
    end
  end

  // lower data byte for the falling half of each clock
  always_ff @(negedge CK or posedge CS_N) begin
    if (CS_N) begin
      lo_ff <= 8'h00;
    end else begin
      lo_ff <= word_ff[7:0]; // RULE3 RULE9
    end
  end

  // clock counter, saturating
  always_ff @(posedge CK or posedge CS_N) begin
    if (CS_N) begin
      cyc_ff <= 6'h00;
    end else if (cyc_ff != `CYC_MAX) begin
      cyc_ff <= cyc_ff + 6'h01;
    end
  end

  // sequencer: decode, latency, streaming, page crossing waits
  always_ff @(posedge CK or posedge CS_N) begin
    if (CS_N) begin
      state_ff     <= ST_CA;
      addr_ff      <= '0;
      start_ff     <= 1'b0;
      linear_ff    <= 1'b0;
      crossed_ff   <= 1'b0;
      words_ff     <= 6'h00;
      wait_ff      <= 5'h00;
      word_ff      <= 16'h0000;
      strobe_en_ff <= 1'b0;
      rd_oe_ff     <= 1'b0; // RULE25
    end else begin
      unique case (state_ff)
        // command phase
        ST_CA: begin
          if (cyc_ff == `CYC_CA2) begin
            // half-page address complete after the second word's falling edge
            addr_ff[ADDR_W-1:`CA_WORD_W] <= ca[`CA_HP_LSB +: (ADDR_W-`CA_WORD_W)]; // RULE5
            start_ff                     <= ca[`CA_RW_BIT]; // RULE5
          end else if (cyc_ff == `CYC_CA_DONE) begin
            addr_ff[`CA_WORD_W-1:0] <= ca[`CA_WORD_W-1:0]; // RULE6
            linear_ff               <= ca[`CA_BURST_BIT]; // RULE4 RULE23
            state_ff                <= ca[`CA_RW_BIT] ? ST_LAT : ST_SKIP; // RULE2 RULE4
          end
        end
        // host keeps clocking through the latency
        ST_LAT: begin
          if (cyc_ff == `DATA_LEAD + {1'b0, lat_clk}) begin // RULE7
            state_ff     <= ST_DATA;
            rd_oe_ff     <= 1'b1; // RULE25
            strobe_en_ff <= 1'b1; // RULE8
            word_ff      <= ARRAY_DATA; // RULE8
            words_ff     <= 6'h01;
            // a first word at a page end crosses straight after it
            wait_ff      <= cross_now ? lat_clk - 5'h01 : 5'h00; // RULE24
            crossed_ff   <= cross_now;
            addr_ff      <= linear_ff ? addr_ff + ONE
                                      : (addr_ff & ~wmask) | ((addr_ff + ONE) & wmask); // RULE11
          end
        end
        // streaming runs until select rises
        ST_DATA: begin
          if (wait_ff != 5'h00) begin
            // invalid clocks: strobe held low
            wait_ff      <= wait_ff - 5'h01; // RULE24
            strobe_en_ff <= 1'b0; // RULE24
          end else begin
            strobe_en_ff <= 1'b1; // RULE9 RULE10
            word_ff      <= ARRAY_DATA; // RULE10
            if (words_ff != `CYC_MAX) begin
              words_ff <= words_ff + 6'h01;
            end
            if (!linear_ff && hyb_switch) begin
              // hybrid: wrap block finished, continue linearly after it
              linear_ff <= 1'b1; // RULE12
              addr_ff   <= (addr_ff | wmask) + ONE; // RULE12
            end else if (linear_ff) begin
              addr_ff <= addr_ff + ONE; // RULE11 RULE15
            end else begin
              addr_ff <= (addr_ff & ~wmask) | ((addr_ff + ONE) & wmask); // RULE11 RULE13
            end
            if (cross_now && {1'b0, lat_clk} > words_ff + 6'h01) begin
              wait_ff <= 5'(({1'b0, lat_clk}) - (words_ff + 6'h01)); // RULE24 RULE17
            end
            if (cross_now) begin
              crossed_ff <= 1'b1;
            end
          end
        end
        // writes and other transactions leave the bus alone
        ST_SKIP: begin
          rd_oe_ff <= 1'b0; // RULE2
        end
      endcase
    end
  end

  // hybrid switch and first page crossing detection for the word just sent
  always_comb begin
    hyb_switch = cfg_s2_ff[7] && ((words_ff + 6'h01) == 6'((wmask[5:0]) + 6'h01)); // RULE12
    cross_now  = !crossed_ff && (addr_ff[3:0] == `PAGE_MASK)
                 && (linear_ff || hyb_switch
                     || wrap_sel_t'(cfg_s2_ff[6:5]) == WRAP64B); // RULE16 RULE17 RULE24
  end

  // double-rate outputs: strobe follows the clock only on valid clocks
  assign DQ_OUT      = CK ? word_ff[15:8] : lo_ff; // RULE3 RULE9
  assign DQ_OE       = rd_oe_ff; // RULE25
  assign READ_DATA_STROBE_OUT    = CK & strobe_en_ff; // RULE8 RULE9
  assign READ_DATA_STROBE_OE     = rd_oe_ff; // RULE25
  assign ARRAY_ADDR  = addr_ff;
  assign ARRAY_START = start_ff;

  // ---------------- checks ----------------
  a_bus_only_data: assert property (@(posedge CK) disable iff (CS_N)
    rd_oe_ff |-> state_ff == ST_DATA) // RULE25
    else $error("bus driven outside the data phase");
  a_write_off_bus: assert property (@(posedge CK) disable iff (CS_N)
    state_ff == ST_SKIP |-> !rd_oe_ff && !strobe_en_ff) // RULE2
    else $error("non-read transaction drove the bus");
  a_first_data_time: assert property (@(posedge CK) disable iff (CS_N)
    (state_ff == ST_LAT && cyc_ff == `DATA_LEAD + {1'b0, lat_clk}) |=> strobe_en_ff && rd_oe_ff) // RULE8
    else $error("data did not start when latency ended");
  a_no_early_data: assert property (@(posedge CK) disable iff (CS_N)
    (cyc_ff <= `DATA_LEAD + {1'b0, lat_clk}) |-> !strobe_en_ff) // RULE7
    else $error("strobe toggled before latency expired");
  a_access_start: assert property (@(posedge CK) disable iff (CS_N)
    (cyc_ff == `CYC_CA_DONE && ca[`CA_RW_BIT]) |-> start_ff) // RULE5
    else $error("array access not launched after half-page");
  a_wait_no_strobe: assert property (@(posedge CK) disable iff (CS_N)
    (state_ff == ST_DATA && wait_ff != 5'h00) |=> !strobe_en_ff) // RULE24
    else $error("strobe toggled during a page crossing wait");

  a_short_wrap_nowait: assert property (@(posedge CK) disable iff (CS_N)
    (!linear_ff && !cfg_s2_ff[7] && wrap_sel_t'(cfg_s2_ff[6:5]) != WRAP64B) |-> wait_ff == 5'h00) // RULE16
    else $error("short wrapped burst inserted wait clocks");

  a_linear_rollover: assert property (@(posedge CK) disable iff (CS_N)
    (state_ff == ST_DATA && linear_ff && wait_ff == 5'h00 && addr_ff == '1) |=> addr_ff == '0) // RULE15
    else $error("linear address did not roll over to zero");

  a_wrap_stays: assert property (@(posedge CK) disable iff (CS_N)
    (state_ff == ST_DATA && !linear_ff && !cfg_s2_ff[7]) |=> ($stable(addr_ff & ~wmask))) // RULE11
    else $error("wrapped burst left its block");

  a_nv_default: assert property (@(posedge CLOCK)
    $past(SRST) |-> nv_lat_ff == `NV_LAT_DEFAULT) // RULE22
    else $error("non-volatile latency not at its default after reset");

endmodule : flash_burst_read

// [test/host_model.sv]
// host bus controller model: frames reads, clocks the link, collects strobed words
`timescale 1ns/100ps
module host_model (
  // link pins driven by the host
  output logic       CK,
  output logic       CK_COMP,
  output logic       CS_N,
  output logic [7:0] DQ_IN,
  // link pins driven by the device
  input  wire logic [7:0] DQ_OUT,
  input  wire logic       DQ_OE,
  input  wire logic       READ_DATA_STROBE_OUT,
  input  wire logic       READ_DATA_STROBE_OE
);
  // quarter of the 125 ns link period; 8 MHz is within every latency code's limit
  localparam realtime QP = 31.25;
  logic [15:0] got_w[$];           // words seen on strobe edges
  int          got_c[$];           // clock index of each word
  logic [7:0]  hi_byte;            // byte taken on the strobe rise
  logic        hi_ok;              // strobe was high at the rise
  assign CK_COMP = ~CK;
  // idle: clock low, deselected
  initial begin
    CK = 1'b0;
    CS_N = 1'b1;
    DQ_IN = 8'h00;
  end
  // one frame of nclk clocks; command bytes on both edges of the first three
  task automatic frame(input logic [47:0] ca, input int nclk);
    got_w.delete();
    got_c.delete();
    // deselected clock pulses let the config settings cross over
    repeat (2) begin
      #QP CK = 1'b1;
      #(2 * QP) CK = 1'b0;
      #QP;
    end
    CS_N = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      // released bus shows a changing pattern, not the last value
      DQ_IN = (i < 3) ? ca[47 - 16 * i -: 8] : ~DQ_IN;
      #QP CK = 1'b1;
      #5 hi_ok = READ_DATA_STROBE_OE & READ_DATA_STROBE_OUT;
      hi_byte = DQ_OUT;
      #(QP - 5) DQ_IN = (i < 3) ? ca[39 - 16 * i -: 8] : ~DQ_IN;
      #QP CK = 1'b0;
      #5 if (hi_ok & READ_DATA_STROBE_OE & ~READ_DATA_STROBE_OUT) begin
        got_w.push_back({hi_byte, DQ_OUT});
        got_c.push_back(i);
      end
      #(QP - 5);
    end
    CS_N = 1'b1;
    DQ_IN = ~DQ_IN;
    #(4 * QP);
  endtask : frame
endmodule : host_model

// [test/testbench.sv]
// self-checking bench for the burst read sequencer
`timescale 1ns/100ps
module testbench;
  import flash_rd_pkg::*;
  // one read: start word, burst type, latency setup, wrap setup, frame length
  typedef struct {
    logic [24:0] addr;
    logic        lin;
    logic [3:0]  code;
    logic        use_nv;
    wrap_sel_t   ws;
    logic        hyb;
    int          nclk;
  } row_t;
  logic        CLOCK = 1'b0;
  logic        SRST, USE_NV_LAT, NV_LAT_WE, HYBRID_EN;
  logic [3:0]  VOL_LAT_CODE, NV_LAT_DATA, NV_LAT_CODE, nv_exp;
  wrap_sel_t   WRAP_SEL;
  logic        CK, CK_COMP, CS_N, DQ_OE, READ_DATA_STROBE_OUT, READ_DATA_STROBE_OE, ARRAY_START, READ_ACTIVE;
  logic [7:0]  DQ_IN, DQ_OUT, READ_COUNT;
  logic [24:0] ARRAY_ADDR;
  logic [15:0] ARRAY_DATA;
  logic [15:0] exp_w[$];  // expected words
  int          exp_c[$];  // expected clock index per word
  int          num_errors = 0;
  int          n_tests = 0;
  // ordinary reads
  row_t rows [10] = '{
    '{25'h0000007, 1'b1, 4'h0, 1'b0, WRAP16B, 1'b0, 20}, '{25'h0123457, 1'b1, 4'h7, 1'b0, WRAP16B, 1'b0, 30},
    '{25'h0000001, 1'b1, 4'h0, 1'b1, WRAP16B, 1'b0, 36}, '{25'h0000005, 1'b0, 4'h2, 1'b0, WRAP16B, 1'b0, 26},
    '{25'h0000013, 1'b0, 4'h3, 1'b0, WRAP32B, 1'b0, 30}, '{25'h000001d, 1'b0, 4'h4, 1'b0, WRAP64B, 1'b0, 44},
    '{25'h0000006, 1'b0, 4'h1, 1'b0, WRAP16B, 1'b1, 34}, '{25'h1fffffe, 1'b1, 4'h0, 1'b0, WRAP16B, 1'b0, 16},
    '{25'h0000020, 1'b1, 4'hc, 1'b0, WRAP16B, 1'b0, 24}, '{25'h000000f, 1'b1, 4'h0, 1'b0, WRAP16B, 1'b0, 16}};
  // array contents follow the word address
  assign ARRAY_DATA = ARRAY_ADDR[15:0] ^ 16'h5a00;
  always #2.5 CLOCK = ~CLOCK;
  flash_burst_read #(.ADDR_W(25)) u_dut (
    .CLOCK(CLOCK), .SRST(SRST), .CK(CK), .CK_COMP(CK_COMP), .CS_N(CS_N), .DQ_IN(DQ_IN),
    .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .READ_DATA_STROBE_OUT(READ_DATA_STROBE_OUT), .READ_DATA_STROBE_OE(READ_DATA_STROBE_OE), .ARRAY_ADDR(ARRAY_ADDR),
    .ARRAY_START(ARRAY_START), .ARRAY_DATA(ARRAY_DATA), .VOL_LAT_CODE(VOL_LAT_CODE), .USE_NV_LAT(USE_NV_LAT),
    .NV_LAT_WE(NV_LAT_WE), .NV_LAT_DATA(NV_LAT_DATA), .WRAP_SEL(WRAP_SEL), .HYBRID_EN(HYBRID_EN),
    .NV_LAT_CODE(NV_LAT_CODE), .READ_ACTIVE(READ_ACTIVE), .READ_COUNT(READ_COUNT));
  host_model u_host (
    .CK(CK), .CK_COMP(CK_COMP), .CS_N(CS_N), .DQ_IN(DQ_IN),
    .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .READ_DATA_STROBE_OUT(READ_DATA_STROBE_OUT), .READ_DATA_STROBE_OE(READ_DATA_STROBE_OE));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  // verdict and end of run
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // command words: read flag, memory space, burst type, half-page, word
  function automatic logic [47:0] ca_of(input logic rd, input logic lin, input logic [24:0] a);
    return {rd, 1'b0, lin, 7'h00, a[24:3], 13'h0000, a[2:0]};
  endfunction : ca_of
  // word order and clock index of every word the host should see
  task automatic expect_words(input row_t r, input int lat);
    int          clk, sent, blk;
    logic        waited;
    logic [24:0] a, nx, m;
    exp_w.delete();
    exp_c.delete();
    blk = (r.ws == WRAP16B) ? 8 : (r.ws == WRAP32B) ? 16 : 32;
    m = 25'(blk - 1);
    a = r.addr;
    clk = 2 + lat;
    sent = 0;
    waited = 1'b0;
    while (clk < r.nclk) begin
      exp_w.push_back(a[15:0] ^ 16'h5a00);
      exp_c.push_back(clk);
      sent++;
      clk++;
      if (!r.lin && !(r.hyb && sent >= blk)) nx = (a & ~m) | ((a + 25'h1) & m);
      else if (!r.lin && sent == blk) nx = (a | m) + 25'h1;
      else nx = a + 25'h1;
      // first page change waits for the remaining latency
      if (!waited && nx[24:4] != a[24:4]) begin
        waited = 1'b1;
        if (lat > sent) clk += lat - sent;
      end
      a = nx;
    end
  endtask : expect_words
  // one read frame with its comparisons
  task automatic run_read(input row_t r);
    logic [3:0] c;
    @(negedge CLOCK);
    VOL_LAT_CODE = r.code;
    USE_NV_LAT = r.use_nv;
    WRAP_SEL = r.ws;
    HYBRID_EN = r.hyb;
    c = r.use_nv ? nv_exp : r.code;
    expect_words(r, (c > 4'hb) ? 16 : int'(c) + 5);
    // while the frame runs, look at the access and activity flags once data flows
    fork
      u_host.frame(ca_of(1'b1, r.lin, r.addr), r.nclk);
      begin
        @(negedge CS_N);
        while (u_host.got_w.size() == 0 && CS_N == 1'b0) @(negedge CLOCK);
        check({30'h0, ARRAY_START, READ_ACTIVE}, 32'h3, "access and activity");
      end
    join
    check(32'(u_host.got_w.size()), 32'(exp_w.size()), "word count");
    foreach (exp_w[i]) if (i < u_host.got_w.size()) begin
      check({16'h0, u_host.got_w[i]}, {16'h0, exp_w[i]}, "data word");
      check(32'(u_host.got_c[i]), 32'(exp_c[i]), "word clock");
    end
    check({30'h0, DQ_OE, READ_DATA_STROBE_OE}, 32'h0, "bus release");
  endtask : run_read
  // hang guard
  initial begin
    #300000;
    num_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    report_and_stop();
  end
  // main sequence
  initial begin
    SRST = 1'b1;
    NV_LAT_WE = 1'b0;
    NV_LAT_DATA = 4'h0;
    VOL_LAT_CODE = 4'h0;
    USE_NV_LAT = 1'b0;
    WRAP_SEL = WRAP16B;
    HYBRID_EN = 1'b0;
    nv_exp = 4'hb;
    repeat (6) @(negedge CLOCK);
    SRST = 1'b0;
    check({28'h0, NV_LAT_CODE}, 32'hb, "factory latency");
    check({24'h0, READ_COUNT}, 32'h0, "read count at reset");
    $display("test reset done");
    foreach (rows[i]) begin
      run_read(rows[i]);
      $display("test row %0d done", i);
    end
    // every latency code, reserved ones included
    for (int k = 0; k < 16; k++) run_read('{25'h40, 1'b1, 4'(k), 1'b0, WRAP16B, 1'b0, 21});
    $display("test latency codes done");
    // a write frame must leave the bus alone
    u_host.frame(ca_of(1'b0, 1'b1, 25'h40), 20);
    check(32'(u_host.got_w.size()), 32'h0, "write frame words");
    check({24'h0, READ_COUNT}, 32'd26, "read count");
    $display("test write frame done");
    // load the non-volatile code and read with it
    @(negedge CLOCK);
    NV_LAT_DATA = 4'h3;
    NV_LAT_WE = 1'b1;
    @(negedge CLOCK);
    NV_LAT_WE = 1'b0;
    nv_exp = 4'h3;
    @(negedge CLOCK);
    check({28'h0, NV_LAT_CODE}, 32'h3, "stored latency");
    run_read('{25'h40, 1'b1, 4'h0, 1'b1, WRAP16B, 1'b0, 20});
    $display("test stored latency done");
    // second reset in mid-run
    @(negedge CLOCK);
    SRST = 1'b1;
    repeat (2) @(negedge CLOCK);
    SRST = 1'b0;
    check({28'h0, NV_LAT_CODE}, 32'hb, "latency after reset");
    check({24'h0, READ_COUNT}, 32'h0, "count after reset");
    $display("test second reset done");
    report_and_stop();
  end
endmodule : testbench
